// *** src/stb_broadcast_regs.sv ***
// Purpose: Broadcast mask, adjust and literal registers of the sequencer
// Assumes: Step decoder presents one-cycle step strobes on sys_clk
// Notes:   Trigger outputs are one-cycle registered pulses
`timescale 1ns/100ps
`default_nettype none
module stb_broadcast_regs (
  // Clock and reset
  input  wire logic                       sys_clk,
  input  wire logic                       rstn,
  // Register port
  input  wire logic [stb_pkg::ADDR_W-1:0] regAddr,
  input  wire logic [stb_pkg::DATA_W-1:0] regWdata,
  input  wire logic                       regWr,
  input  wire logic                       regRd,
  output logic      [stb_pkg::DATA_W-1:0] regRdata,
  // Sequencer state
  input  wire logic                       sequencerEnable,
  input  wire logic                       sequencerStart,
  // Step commands
  input  wire logic                       controlStep,
  input  wire logic [3:0]                 controlOption,
  input  wire logic                       literalStep,
  input  wire logic                       addStep,
  input  wire logic [1:0]                 addTarget,
  // Peripheral triggers
  output logic      [3:0]                 convTrig,
  output logic      [3:0]                 captureTrig,
  output logic      [3:0]                 compareClk,
  output logic      [3:0]                 compareTrig,
  // Converter channel select write
  output logic                            chanSelWr,
  output logic      [stb_pkg::DATA_W-1:0] chanSelData
);
  import stb_pkg::*;

  logic [DATA_W-1:0] mask_q;
  logic [DATA_W-1:0] adjust_q;
  logic [DATA_W-1:0] literal_q;
  logic [DATA_W-1:0] bankRd;
  logic [DATA_W-1:0] bankAdd;
  logic [DATA_W-1:0] addSum;
  logic              locked;
  logic              bcast;
  logic              swWr;
  logic              bankWr;
  logic [1:0]        bankSel;
  logic [DATA_W-1:0] bankData;
  logic [ADDR_W-1:0] rdAddr_q;
  logic              rdPend_q;

  function automatic logic isLimit(input logic [ADDR_W-1:0] a);
    return a == OFF_TLIM || a == OFF_CLIM || a == OFF_SDLIM;
  endfunction

  function automatic logic [1:0] limSel(input logic [ADDR_W-1:0] a);
    case (a)
      OFF_TLIM:  limSel = TGT_TIMER;
      OFF_CLIM:  limSel = TGT_COUNT;
      OFF_SDLIM: limSel = TGT_DELAY;
      default:   limSel = TGT_LIT;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // Write lock and step decode
  // ---------------------------------------------------------------
  assign locked = sequencerEnable && sequencerStart;
  assign swWr   = regWr && !locked;
  // Broadcast needs the all-ones option; other options never fire
  assign bcast  = controlStep && controlOption == BCAST_OPTION;
  assign addSum = bankAdd + adjust_q;

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      mask_q <= RST_WORD;
    end else if (swWr && regAddr == OFF_MASK) begin
      mask_q <= regWdata;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      adjust_q <= RST_WORD;
    end else if (swWr && regAddr == OFF_ADJUST) begin
      adjust_q <= regWdata;
    end
  end

  // Step update wins over a software write in the same cycle
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      literal_q <= RST_WORD;
    end else if (addStep && addTarget == TGT_LIT) begin
      literal_q <= literal_q + adjust_q;
    end else if (swWr && regAddr == OFF_LIT) begin
      literal_q <= regWdata;
    end
  end

  always_comb begin
    bankWr   = 1'b0;
    bankSel  = TGT_LIT;
    bankData = regWdata;
    if (addStep && addTarget != TGT_LIT) begin
      bankWr   = 1'b1;
      bankSel  = addTarget;
      bankData = addSum;
    end else if (swWr && isLimit(regAddr)) begin
      bankWr  = 1'b1;
      bankSel = limSel(regAddr);
    end
  end

  stb_limit_bank uBank (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .wrEn    (bankWr),
    .wrSel   (bankSel),
    .wrData  (bankData),
    .rdSel   (limSel(regAddr)),
    .rdData  (bankRd),
    .addSel  (addTarget),
    .addData (bankAdd)
  );

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rdAddr_q <= OFF_MASK;
      rdPend_q <= 1'b0;
    end else begin
      rdAddr_q <= regAddr;
      rdPend_q <= regRd;
    end
  end

  // Data only in the cycle after the strobe; unmapped reads zero
  always_comb begin
    regRdata = RST_WORD;
    if (rdPend_q) begin
      case (rdAddr_q)
        OFF_MASK:   regRdata = mask_q;
        OFF_ADJUST: regRdata = adjust_q;
        OFF_LIT:    regRdata = literal_q;
        OFF_STATUS: regRdata = {{(DATA_W-1){1'b0}}, locked};
        OFF_TLIM,
        OFF_CLIM,
        OFF_SDLIM:  regRdata = bankRd;
        default:    regRdata = RST_WORD;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Broadcast triggers
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      convTrig    <= 4'h0;
      captureTrig <= 4'h0;
      compareClk  <= 4'h0;
      compareTrig <= 4'h0;
    end else begin
      convTrig    <= bcast ? mask_q[CONV_LSB +: 4] : 4'h0;
      captureTrig <= bcast ? mask_q[CAPT_LSB +: 4] : 4'h0;
      compareClk  <= bcast ? mask_q[CCLK_LSB +: 4] : 4'h0;
      compareTrig <= bcast ? mask_q[CTRG_LSB +: 4] : 4'h0;
    end
  end

  // ---------------------------------------------------------------
  // Channel select write
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      chanSelWr   <= 1'b0;
      chanSelData <= RST_WORD;
    end else begin
      chanSelWr <= controlStep && literalStep;
      if (controlStep && literalStep) begin
        chanSelData <= literal_q;
      end
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_conv_trig: assert property (@(posedge sys_clk) disable iff (!rstn)
    bcast |=> convTrig == $past(mask_q[CONV_LSB +: 4]))
    else $error("converter trigger mismatch");
  a_capt_trig: assert property (@(posedge sys_clk) disable iff (!rstn)
    bcast |=> captureTrig == $past(mask_q[CAPT_LSB +: 4]))
    else $error("capture trigger mismatch");
  a_cmp_clk_pulse: assert property (@(posedge sys_clk) disable iff (!rstn)
    bcast |=> compareClk == $past(mask_q[CCLK_LSB +: 4]))
    else $error("compare clock mismatch");
  a_cmp_trig: assert property (@(posedge sys_clk) disable iff (!rstn)
    bcast |=> compareTrig == $past(mask_q[CTRG_LSB +: 4]))
    else $error("compare trigger mismatch");
  a_lock_mask: assert property (@(posedge sys_clk) disable iff (!rstn)
    locked |=> $stable(mask_q) && $stable(adjust_q) &&
      ($stable(literal_q) || $past(addStep)))
    else $error("locked register changed");
  a_no_stray: assert property (@(posedge sys_clk) disable iff (!rstn)
    !bcast |=> convTrig == 4'h0 && captureTrig == 4'h0 &&
      compareClk == 4'h0 && compareTrig == 4'h0)
    else $error("trigger without broadcast step");
  a_lit_add: assert property (@(posedge sys_clk) disable iff (!rstn)
    addStep && addTarget == TGT_LIT |=>
      literal_q == DATA_W'($past(literal_q) + $past(adjust_q)))
    else $error("literal add wrong");
  sequence sLitStep;
    controlStep && literalStep;
  endsequence
  a_chan_sel: assert property (@(posedge sys_clk) disable iff (!rstn)
    sLitStep |=> chanSelWr && chanSelData == $past(literal_q))
    else $error("channel select write wrong");
endmodule
`default_nettype wire

// *** src/stb_limit_bank.sv ***
// Purpose: Small store for the three limit words the add step adjusts
// Assumes: One write port, one registered read port
// Notes:   Step write has priority over software write
`timescale 1ns/100ps
`default_nettype none
module stb_limit_bank (
  // Clock and reset
  input  wire logic                       sys_clk,
  input  wire logic                       rstn,
  // Write port
  input  wire logic                       wrEn,
  input  wire logic [1:0]                 wrSel,
  input  wire logic [stb_pkg::DATA_W-1:0] wrData,
  // Read port
  input  wire logic [1:0]                 rdSel,
  output logic      [stb_pkg::DATA_W-1:0] rdData,
  // Add operand port, read combinationally
  input  wire logic [1:0]                 addSel,
  output logic      [stb_pkg::DATA_W-1:0] addData
);
  import stb_pkg::*;
  logic [DATA_W-1:0] mem_q [0:2];

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      mem_q[0] <= RST_WORD;
      mem_q[1] <= RST_WORD;
      mem_q[2] <= RST_WORD;
    end else if (wrEn && wrSel != TGT_LIT) begin
      mem_q[wrSel] <= wrData;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rdData <= RST_WORD;
    end else if (rdSel != TGT_LIT) begin
      rdData <= mem_q[rdSel];
    end else begin
      rdData <= RST_WORD;
    end
  end

  assign addData = (addSel != TGT_LIT) ? mem_q[addSel] : RST_WORD;
endmodule
`default_nettype wire

// *** src/stb_pkg.sv ***
// Purpose: Shared constants for the step trigger broadcast registers
// Assumes: 16-bit register words on a plain strobe port
// Notes:   Offsets are word indices on the register port
package stb_pkg;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned ADDR_W = 4;
  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [3:0] OFF_MASK   = 4'h0;
  localparam logic [3:0] OFF_ADJUST = 4'h1;
  localparam logic [3:0] OFF_LIT    = 4'h2;
  localparam logic [3:0] OFF_STATUS = 4'h3;
  localparam logic [3:0] OFF_TLIM   = 4'h4;
  localparam logic [3:0] OFF_CLIM   = 4'h5;
  localparam logic [3:0] OFF_SDLIM  = 4'h6;
  localparam logic [15:0] RST_WORD  = 16'h0000;
  // ---------------------------------------------------------------
  // Mask fields
  // ---------------------------------------------------------------
  localparam int unsigned CONV_LSB = 12;
  localparam int unsigned CAPT_LSB = 8;
  localparam int unsigned CCLK_LSB = 4;
  localparam int unsigned CTRG_LSB = 0;
  localparam logic [3:0] BCAST_OPTION = 4'hF;
  // Add step targets
  localparam logic [1:0] TGT_TIMER = 2'h0;
  localparam logic [1:0] TGT_COUNT = 2'h1;
  localparam logic [1:0] TGT_DELAY = 2'h2;
  localparam logic [1:0] TGT_LIT   = 2'h3;
endpackage

// *** verif/stb_periph_model.sv ***
// Purpose: Behavioural far side: converter, capture and compare units
// Assumes: Triggers and channel select writes are one-cycle pulses
// Notes:   Counts every trigger pulse so the bench can spot doubles or misses
`timescale 1ns/100ps
`default_nettype none
module stb_periph_model (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  // Trigger lines, converter in the top nibble
  input  wire logic [15:0] trigIn,
  // Channel select write
  input  wire logic        chanSelWr,
  input  wire logic [15:0] chanSelData,
  // Observed state
  output logic      [7:0]  pulseCnt [16],
  output logic      [15:0] chanSel
);
  // Counts wrap past 255, well beyond this run
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < 16; i++) pulseCnt[i] <= 8'h00;
    end else begin
      for (int i = 0; i < 16; i++) pulseCnt[i] <= pulseCnt[i] + trigIn[i];
    end
  end
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) chanSel <= 16'h0000;
    else if (chanSelWr) chanSel <= chanSelData;
  end
endmodule
`default_nettype wire

// *** verif/step_trigger_broadcast_regs_tb.sv ***
// Purpose: Self-checking bench for the broadcast register block
// Assumes: Strobe register port, one-cycle step pulses
// Notes:   Expected values come from the mask field layout
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin \
  num_errors++; $display("Error %0t: got %h exp %h", $time, g, e); end end
module step_trigger_broadcast_regs_tb;
  import stb_pkg::*;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [15:0] regWdata = 16'h0000;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic sequencerEnable = 1'b0;
  logic sequencerStart = 1'b0;
  logic controlStep = 1'b0;
  logic [3:0] controlOption = 4'h0;
  logic literalStep = 1'b0;
  logic addStep = 1'b0;
  logic [1:0] addTarget = 2'h0;
  logic [3:0] convTrig, captureTrig, compareClk, compareTrig;
  logic chanSelWr;
  logic [15:0] chanSelData, regRdata, trigAll, chanSel, m;
  logic [7:0] pulseCnt [16];
  logic [3:0] tadr [4] = '{OFF_TLIM, OFF_CLIM, OFF_SDLIM, OFF_LIT};
  int num_errors = 0;
  int checks_done = 0;
  assign trigAll = {convTrig, captureTrig, compareClk, compareTrig};
  always #5 sys_clk = ~sys_clk;
  stb_broadcast_regs DUT (.sys_clk(sys_clk), .rstn(rstn),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .sequencerEnable(sequencerEnable),
    .sequencerStart(sequencerStart), .controlStep(controlStep),
    .controlOption(controlOption), .literalStep(literalStep),
    .addStep(addStep), .addTarget(addTarget), .convTrig(convTrig),
    .captureTrig(captureTrig), .compareClk(compareClk),
    .compareTrig(compareTrig), .chanSelWr(chanSelWr),
    .chanSelData(chanSelData));
  stb_periph_model periph (.sys_clk(sys_clk), .rstn(rstn),
    .trigIn(trigAll), .chanSelWr(chanSelWr), .chanSelData(chanSelData),
    .pulseCnt(pulseCnt), .chanSel(chanSel));
  // ---------------------------------------------------------------
  // Access tasks
  // ---------------------------------------------------------------
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask
  task automatic chk_rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge sys_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1;
    `CHK(regRdata, e)
  endtask
  task automatic step(input logic c, l, a, input logic [3:0] o,
                      input logic [1:0] t);
    @(posedge sys_clk);
    controlStep <= c;
    literalStep <= l;
    addStep <= a;
    controlOption <= o;
    addTarget <= t;
    @(posedge sys_clk);
    controlStep <= 1'b0;
    literalStep <= 1'b0;
    addStep <= 1'b0;
    #1;
  endtask
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    repeat (8) @(posedge sys_clk);
    rstn <= 1'b1;
    for (int i = 0; i < 3; i++) chk_rd(i[3:0], RST_WORD);
    $display("Test reset values done");
    for (int i = 0; i < 16; i++) begin
      m = 16'h0001 << i;
      wr(OFF_MASK, m);
      step(1'b1, 1'b0, 1'b0, BCAST_OPTION, 2'h0);
      `CHK(trigAll, m)
      @(posedge sys_clk);
      #1;
      `CHK(trigAll, 16'h0000)
    end
    for (int i = 0; i < 16; i++) `CHK(pulseCnt[i], 8'h01)
    $display("Test mask walk done");
    wr(OFF_MASK, 16'hFFFF);
    for (int o = 0; o < 15; o++) begin
      step(1'b1, 1'b0, 1'b0, o[3:0], 2'h0);
      `CHK(trigAll, 16'h0000)
    end
    $display("Test option filter done");
    wr(OFF_LIT, 16'hA5C3);
    step(1'b1, 1'b1, 1'b0, 4'h0, 2'h0);
    `CHK(chanSelWr, 1'b1)
    @(posedge sys_clk);
    #1;
    `CHK(chanSel, 16'hA5C3)
    `CHK(chanSelWr, 1'b0)
    $display("Test literal step done");
    // Limit values near the top so their sums wrap past zero; the literal starts at zero
    wr(OFF_ADJUST, 16'h0003);
    for (int t = 0; t < 4; t++) begin
      wr(tadr[t], 16'hFFFD + t[15:0]);
      step(1'b0, 1'b0, 1'b1, 4'h0, t[1:0]);
      chk_rd(tadr[t], t[15:0]);
    end
    $display("Test add step done");
    @(posedge sys_clk);
    sequencerEnable <= 1'b1;
    sequencerStart <= 1'b1;
    for (int i = 0; i < 3; i++) wr(i[3:0], 16'h1234);
    wr(OFF_TLIM, 16'h1234);
    chk_rd(OFF_TLIM, 16'h0000);
    chk_rd(OFF_MASK, 16'hFFFF);
    chk_rd(OFF_ADJUST, 16'h0003);
    chk_rd(OFF_LIT, 16'h0003);
    chk_rd(OFF_STATUS, 16'h0001);
    step(1'b1, 1'b0, 1'b0, BCAST_OPTION, 2'h0);
    `CHK(trigAll, 16'hFFFF)
    @(posedge sys_clk);
    sequencerStart <= 1'b0;
    wr(OFF_MASK, 16'h1234);
    chk_rd(OFF_MASK, 16'h1234);
    wr(4'hF, 16'hFFFF);
    chk_rd(4'hF, 16'h0000);
    @(posedge sys_clk);
    #1;
    `CHK(regRdata, 16'h0000)
    $display("Test lock and unmapped done");
    @(posedge sys_clk);
    rstn <= 1'b0;
    @(posedge sys_clk);
    rstn <= 1'b1;
    chk_rd(OFF_MASK, RST_WORD);
    `CHK(pulseCnt[15], 8'h00)
    $display("Test mid-run reset done");
    give_verdict();
  end
  initial begin
    repeat (3000) @(posedge sys_clk);
    num_errors++;
    give_verdict();
  end
endmodule
`default_nettype wire
